// ---- bench/complement_compare_branch_exec_test.sv ----
// self-checking bench for the complement, compare and branch unit
`timescale 1ns/10ps
module complement_compare_branch_exec_test;
    import cmpbr_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic start = 1'b0;
    exec_req_t req = '0;
    logic [7:0] flags_in = 8'h00;
    logic busy;
    logic done;
    exec_res_t res;
    logic [7:0] faddr;
    int err_total = 0;
    int total_checks = 0;
    int cycles = 0;
    int n;

    cmpbr_exec uut (.CLK_SYS_I(clk), .RST_I(rst), .START_I(start),
        .REQ_I(req), .FLAGS_I(flags_in), .BUSY_O(busy), .DONE_O(done),
        .RES_O(res), .FLAGS_ADDR_O(faddr));

    // 5 ns period for the 200 MHz core clock
    always #2.5 clk = ~clk;

    // hang guard: the whole run needs about 135 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            err_total = err_total + 1;
            final_report();
        end
    end

    task automatic chk8(input string what, input logic [7:0] exp,
                        input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk8

    task automatic chk16(input string what, input logic [15:0] exp,
                         input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk16

    // one request; n ends as edges from accept to done
    task automatic run_op(input logic [1:0] op, input logic [7:0] d,
        input logic [7:0] s, input logic [7:0] p, input logic [7:0] disp,
        input logic [15:0] pc, input logic [7:0] fin, input bit poke);
        @(posedge clk);
        start <= 1'b1;
        req <= '{op: op, dst_val: d, src_val: s, ptr_val: p,
                 disp: disp, pc: pc};
        flags_in <= fin;
        @(posedge clk);
        start <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            // a start while busy must be ignored
            if (poke && n == 3) start <= 1'b1;
            if (poke && n == 4) start <= 1'b0;
            #1;
        end while (done !== 1'b1 && n < 40);
    endtask : run_op

    task automatic test_com(input logic [7:0] d, input logic [7:0] fin);
        logic [7:0] r;
        logic [7:0] f;
        r = ~d;
        f = fin;
        f[FLAG_S] = r[7];
        f[6] = (r == 8'h00);
        f[FLAG_V] = 1'b0;
        run_op(OP_COM, d, 8'h5A, 8'h33, 8'h00, 16'h0100, fin, 1'b0);
        chk16("com cycles", 16'h0004, 16'(n));
        chk8("com result", r, res.dst_val);
        chk8("com flags", f, res.flags);
        chk8("com strobes", 8'h04,
             {5'h00, res.dst_we, res.ptr_we, res.pc_we});
    endtask : test_com

    task automatic test_cmp(input logic [7:0] d, input logic [7:0] s,
                            input logic [7:0] fin);
        logic [7:0] df;
        logic [7:0] f;
        df = d - s;
        f = fin;
        f[FLAG_C] = (s > d);
        f[6] = (df == 8'h00);
        f[FLAG_S] = df[7];
        f[FLAG_V] = (d[7] ^ s[7]) & (df[7] ^ d[7]);
        run_op(OP_CMP, d, s, 8'h21, 8'h00, 16'h0100, fin, 1'b0);
        chk16("cmp cycles", 16'h0004, 16'(n));
        chk8("cmp flags", f, res.flags);
        chk8("cmp strobes", 8'h00,
             {5'h00, res.dst_we, res.ptr_we, res.pc_we});
    endtask : test_cmp

    task automatic test_branch(input logic [1:0] op, input logic [7:0] d,
        input logic [7:0] s, input logic [7:0] p, input logic [7:0] disp,
        input logic [15:0] pc, input logic [7:0] fin);
        bit tk;
        logic [15:0] tgt;
        tk = (op == OP_CIBE) ? (d == s) : (d != s);
        tgt = pc + {{8{disp[7]}}, disp};
        run_op(op, d, s, p, disp, pc, fin, 1'b1);
        chk16("br cycles", tk ? 16'h0012 : 16'h0010, 16'(n));
        chk8("br strobes", {6'h00, 1'b1, tk},
             {5'h00, res.dst_we, res.ptr_we, res.pc_we});
        chk8("br pointer", p + 8'h01, res.ptr_val);
        chk8("br flags", fin, res.flags);
        if (tk) chk16("br target", tgt, res.pc);
        @(posedge clk);
        @(posedge clk);
        #1;
        chk8("busy after refusal", 8'h00, {7'h00, busy});
    endtask : test_branch

    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report

    // reset for 20 cycles, then the scenario list
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        chk8("flags address", 8'hD5, faddr);
        chk8("idle status", 8'h00, {6'h00, busy, done});
        test_com(8'h07, 8'hFF);
        test_com(8'hFF, 8'h00);
        test_cmp(8'h02, 8'h03, 8'h0C);
        test_cmp(8'h80, 8'h01, 8'h00);
        test_cmp(8'h05, 8'h05, 8'hF0);
        test_branch(OP_CIBE, 8'h02, 8'h02, 8'h03, 8'h80, 16'h0010, 8'hA4);
        test_branch(OP_CIBE, 8'h02, 8'h04, 8'hFF, 8'h7F, 16'h0010, 8'h5C);
        test_branch(OP_CIBU, 8'h02, 8'h04, 8'h03, 8'h7F, 16'hFFF0, 8'h00);
        test_branch(OP_CIBU, 8'h09, 8'h09, 8'h10, 8'h80, 16'h0200, 8'hFC);
        final_report();
    end
endmodule : complement_compare_branch_exec_test

// ---- verilog/cmpbr_exec.sv ----
// execution unit for complement, compare and compare-increment-branch
`timescale 1ns/10ps
module cmpbr_exec
    import cmpbr_pkg::*;
(
    // clock and reset
    input wire logic CLK_SYS_I,
    input wire logic RST_I,
    // instruction request
    input wire logic START_I,
    input wire exec_req_t REQ_I,
    input wire logic [7:0] FLAGS_I,
    // status and results
    output logic BUSY_O,
    output logic DONE_O,
    output exec_res_t RES_O,
    output logic [7:0] FLAGS_ADDR_O
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RUN = 3'b010,
        ST_DONE = 3'b100
    } state_t;

    state_t state_q, state_d;
    logic [4:0] cnt_q;
    exec_res_t res_q, res_pend_q;
    logic done_q;

    // shared arithmetic
    wire [7:0] inv_val = ~REQ_I.dst_val;
    wire [8:0] diff9 = {1'b0, REQ_I.dst_val} - {1'b0, REQ_I.src_val};
    wire [7:0] diff = diff9[7:0];
    wire borrow = diff9[8];
    wire ovf = (REQ_I.dst_val[7] != REQ_I.src_val[7]) &&
        (diff[7] != REQ_I.dst_val[7]);
    wire diff_zero = (diff == 8'h00);
    wire is_com = (REQ_I.op == OP_COM);
    wire is_cmp = (REQ_I.op == OP_CMP);
    wire is_br = REQ_I.op[1];
    wire br_take = (REQ_I.op == OP_CIBE) ? diff_zero : !diff_zero;
    wire [15:0] disp_ext = {{8{REQ_I.disp[7]}}, REQ_I.disp};
    wire [15:0] br_target = REQ_I.pc + disp_ext;
    wire [4:0] cyc_len = is_br ? (br_take ? CYC_BR_TAKEN : CYC_BR_NOT) :
        (is_com ? CYC_COM : CYC_CMP);

    // flag formation
    logic [7:0] flags_new;
    always_comb begin
        flags_new = FLAGS_I;
        if (is_com) begin
            flags_new[FLAG_S] = inv_val[7];
            flags_new[FLAG_Z] = (inv_val == 8'h00);
            flags_new[FLAG_V] = 1'b0;
        end else if (is_cmp) begin
            flags_new[FLAG_C] = borrow;
            flags_new[FLAG_Z] = diff_zero;
            flags_new[FLAG_S] = diff[7];
            flags_new[FLAG_V] = ovf;
        end
    end

    // result formation
    exec_res_t res_new;
    always_comb begin
        res_new = '0;
        res_new.flags = flags_new;
        res_new.dst_we = is_com;
        res_new.dst_val = is_com ? inv_val : REQ_I.dst_val;
        res_new.ptr_we = is_br;
        res_new.ptr_val = REQ_I.ptr_val + 8'h01;
        res_new.pc_we = is_br && br_take;
        res_new.pc = br_target;
    end

    // state machine: results held until last cycle, then committed
    wire accept = (state_q == ST_IDLE) && START_I;
    wire last = (state_q == ST_RUN) && (cnt_q == 5'h01);
    always_comb begin
        case (state_q)
            ST_IDLE: state_d = START_I ? ST_RUN : ST_IDLE;
            ST_RUN: state_d = (cnt_q == 5'h01) ? ST_DONE : ST_RUN;
            ST_DONE: state_d = ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    // sequencing registers
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            state_q <= ST_IDLE;
            cnt_q <= 5'h00;
            res_pend_q <= '0;
            res_q <= '0;
            done_q <= 1'b0;
        end else begin
            state_q <= state_d;
            if (accept) begin
                // full length loaded so done lands on edge N
                cnt_q <= cyc_len;
                res_pend_q <= res_new;
            end else if (state_q == ST_RUN) begin
                cnt_q <= cnt_q - 5'h01;
            end
            done_q <= last;
            if (last) begin
                res_q <= res_pend_q;
            end else begin
                res_q.dst_we <= 1'b0;
                res_q.ptr_we <= 1'b0;
                res_q.pc_we <= 1'b0;
            end
        end
    end

    // busy until the commit cycle has passed
    logic busy_q;
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= (state_d != ST_IDLE);
        end
    end

    logic [7:0] faddr_q;
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            faddr_q <= FLAGS_ADDR;
        end else begin
            faddr_q <= FLAGS_ADDR;
        end
    end

    assign BUSY_O = busy_q;
    assign DONE_O = done_q;
    assign RES_O = res_q;
    assign FLAGS_ADDR_O = faddr_q;

    // start accepted to done pulse, with held request snapshot
    logic [4:0] len_q;
    logic [5:0] age_q;
    logic [1:0] op_q;
    logic [7:0] fin_q;
    logic [7:0] dst_q;
    logic [7:0] src_q;
    logic [7:0] ptr_q;
    logic [7:0] disp_q;
    logic [15:0] pc_q;
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            len_q <= 5'h00;
            age_q <= 6'h00;
            op_q <= 2'h0;
            fin_q <= 8'h00;
            dst_q <= 8'h00;
            src_q <= 8'h00;
            ptr_q <= 8'h00;
            disp_q <= 8'h00;
            pc_q <= 16'h0000;
        end else if (accept) begin
            len_q <= cyc_len;
            age_q <= 6'h01;
            op_q <= REQ_I.op;
            fin_q <= FLAGS_I;
            dst_q <= REQ_I.dst_val;
            src_q <= REQ_I.src_val;
            ptr_q <= REQ_I.ptr_val;
            disp_q <= REQ_I.disp;
            pc_q <= REQ_I.pc;
        end else if (age_q != 6'h00 && age_q != 6'h3F) begin
            age_q <= age_q + 6'h01;
        end
    end

    // independent references, formed apart from the datapath above
    wire [8:0] chk_sdiff = {dst_q[7], dst_q} - {src_q[7], src_q};
    wire chk_ovf = (chk_sdiff[8] != chk_sdiff[7]);
    wire signed [15:0] chk_tgt = $signed(pc_q) + $signed(disp_q);

    // done arrives after the counted cycles
    done_timing_a: assert property (
        @(posedge CLK_SYS_I) disable iff (RST_I)
        $rose(done_q) |-> age_q == {1'b0, len_q} + 6'h01)
        else $error("done not at instruction length");
    br_flags_a: assert property (
        @(posedge CLK_SYS_I) disable iff (RST_I)
        done_q && op_q[1] |-> res_q.flags == fin_q)
        else $error("branch changed flags");
    ptr_inc_a: assert property (
        @(posedge CLK_SYS_I) disable iff (RST_I)
        done_q |-> res_q.ptr_we == op_q[1])
        else $error("pointer write mismatch");
    ptr_value_a: assert property (
        @(posedge CLK_SYS_I) disable iff (RST_I)
        done_q && op_q[1] |-> res_q.ptr_val == ptr_q + 8'h01)
        else $error("pointer value wrong");
    cmp_nowrite_a: assert property (
        @(posedge CLK_SYS_I) disable iff (RST_I)
        done_q && op_q == OP_CMP |-> !res_q.dst_we && !res_q.pc_we)
        else $error("compare wrote a result");
    cmp_carry_a: assert property (
        @(posedge CLK_SYS_I) disable iff (RST_I)
        done_q && op_q == OP_CMP |-> res_q.flags[FLAG_C] == (src_q > dst_q))
        else $error("compare carry wrong");
    // compare zero sign overflow, decimal and half kept
    cmp_flags_a: assert property (
        @(posedge CLK_SYS_I) disable iff (RST_I)
        done_q && op_q == OP_CMP |-> res_q.flags[FLAG_Z] == (dst_q == src_q)
        && res_q.flags[FLAG_S] == chk_sdiff[7] && res_q.flags[FLAG_V] ==
        chk_ovf && res_q.flags[FLAG_D] == fin_q[FLAG_D] &&
        res_q.flags[FLAG_H] == fin_q[FLAG_H])
        else $error("compare flags wrong");
    com_value_a: assert property (
        @(posedge CLK_SYS_I) disable iff (RST_I)
        done_q && op_q == OP_COM |-> res_q.dst_we && res_q.dst_val == ~dst_q)
        else $error("complement value wrong");
    com_flags_a: assert property (
        @(posedge CLK_SYS_I) disable iff (RST_I)
        done_q && op_q == OP_COM |-> !res_q.flags[FLAG_V] &&
        res_q.flags[FLAG_C] == fin_q[FLAG_C] &&
        res_q.flags[FLAG_D] == fin_q[FLAG_D] &&
        res_q.flags[FLAG_H] == fin_q[FLAG_H])
        else $error("complement flags wrong");
    com_sz_a: assert property (
        @(posedge CLK_SYS_I) disable iff (RST_I)
        done_q && op_q == OP_COM |-> res_q.flags[FLAG_S] ==
        res_q.dst_val[7] && res_q.flags[FLAG_Z] == (res_q.dst_val == 8'h00))
        else $error("complement sign or zero wrong");
    // equal branch taken only on equal operands
    br_equal_a: assert property (
        @(posedge CLK_SYS_I) disable iff (RST_I)
        done_q && op_q == OP_CIBE |-> res_q.pc_we == (dst_q == src_q))
        else $error("equal branch decision wrong");
    // unequal branch taken only on differing operands
    br_unequal_a: assert property (
        @(posedge CLK_SYS_I) disable iff (RST_I)
        done_q && op_q == OP_CIBU |-> res_q.pc_we == (dst_q != src_q))
        else $error("unequal branch decision wrong");
    br_target_a: assert property (
        @(posedge CLK_SYS_I) disable iff (RST_I)
        done_q && res_q.pc_we |-> res_q.pc == chk_tgt)
        else $error("branch target wrong");
    br_len_a: assert property (
        @(posedge CLK_SYS_I) disable iff (RST_I)
        done_q && op_q[1] |->
        len_q == (res_q.pc_we ? CYC_BR_TAKEN : CYC_BR_NOT))
        else $error("branch length wrong");
    commit_only_a: assert property (
        @(posedge CLK_SYS_I) disable iff (RST_I)
        !done_q |-> !res_q.dst_we && !res_q.ptr_we && !res_q.pc_we)
        else $error("commit outside done");
    // done is a single cycle pulse
    done_pulse_a: assert property (
        @(posedge CLK_SYS_I) disable iff (RST_I)
        done_q |=> !done_q)
        else $error("done longer than one cycle");
    busy_done_a: assert property (
        @(posedge CLK_SYS_I) disable iff (RST_I)
        done_q |-> busy_q)
        else $error("busy low during commit");
    faddr_a: assert property (
        @(posedge CLK_SYS_I) disable iff (RST_I)
        !$past(RST_I) |-> faddr_q == FLAGS_ADDR)
        else $error("flags address wrong");

    cov_com_c: cover property (@(posedge CLK_SYS_I) done_q && op_q == OP_COM);
    cov_cmp_c: cover property (@(posedge CLK_SYS_I) done_q && op_q == OP_CMP);
    cov_take_c: cover property (@(posedge CLK_SYS_I) done_q && res_q.pc_we);
    cov_fall_c: cover property (@(posedge CLK_SYS_I)
        done_q && op_q[1] && !res_q.pc_we);
endmodule : cmpbr_exec

// ---- verilog/cmpbr_pkg.sv ----
// package: flag layout, opcodes, cycle counts and carrier types
package cmpbr_pkg;
    // flags register location and bit positions
    localparam logic [7:0] FLAGS_ADDR = 8'hD5;
    localparam int FLAG_C = 7;
    localparam int FLAG_Z = 6;
    localparam int FLAG_S = 5;
    localparam int FLAG_V = 4;
    localparam int FLAG_D = 3;
    localparam int FLAG_H = 2;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    // operation codes presented by the decoder
    localparam logic [1:0] OP_COM = 2'h0;
    localparam logic [1:0] OP_CMP = 2'h1;
    localparam logic [1:0] OP_CIBE = 2'h2;
    localparam logic [1:0] OP_CIBU = 2'h3;
    // execution lengths in core cycles
    localparam logic [4:0] CYC_COM = 5'h04;
    localparam logic [4:0] CYC_CMP = 5'h04;
    localparam logic [4:0] CYC_BR_TAKEN = 5'h12;
    localparam logic [4:0] CYC_BR_NOT = 5'h10;

    // instruction request from the decoder
    typedef struct packed {
        logic [1:0] op;
        logic [7:0] dst_val;
        logic [7:0] src_val;
        logic [7:0] ptr_val;
        logic [7:0] disp;
        logic [15:0] pc;
    } exec_req_t;

    // committed results
    typedef struct packed {
        logic dst_we;
        logic [7:0] dst_val;
        logic ptr_we;
        logic [7:0] ptr_val;
        logic pc_we;
        logic [15:0] pc;
        logic [7:0] flags;
    } exec_res_t;
endpackage : cmpbr_pkg
